// file: pcm_pkg.sv
package pcm_pkg;
    // ==================================================
    // register indices (word index; byte address = 4 * index)
    localparam logic [15:0] IDX_BROWNOUT_CONFIG = 16'h0985;
    localparam logic [15:0] IDX_CLOCK_OUTPUT_CONTROL = 16'h7010;
    localparam logic [15:0] IDX_PLL_STATUS = 16'h7011;
    localparam logic [15:0] IDX_CLOCK_SOURCE_CONTROL = 16'h7012;
    localparam logic [15:0] IDX_PLL_LOCK_PERIOD = 16'h7013;
    localparam logic [15:0] IDX_OSC_ONE_TRIM = 16'h7014;
    localparam logic [15:0] IDX_OSC_TWO_TRIM = 16'h7016;
    localparam logic [15:0] IDX_PERIPH_CLOCK_GATE_C = 16'h7019;
    localparam logic [15:0] IDX_LOW_SPEED_PRESCALER = 16'h701B;
    localparam logic [15:0] IDX_PERIPH_CLOCK_GATE_A = 16'h701C;
    localparam logic [15:0] IDX_PERIPH_CLOCK_GATE_B = 16'h701D;
    localparam logic [15:0] IDX_LOW_POWER_CONTROL = 16'h701E;
    localparam logic [15:0] IDX_PERIPH_CLOCK_GATE_D = 16'h7020;
    localparam logic [15:0] IDX_PLL_RATIO_CONTROL = 16'h7021;
    localparam logic [15:0] IDX_SYSTEM_CONTROL_STATUS = 16'h7022;
    localparam logic [15:0] IDX_WATCHDOG_COUNTER = 16'h7023;
    localparam logic [15:0] IDX_WATCHDOG_KEY = 16'h7025;
    localparam logic [15:0] IDX_WATCHDOG_CONTROL = 16'h7029;
    localparam logic [15:0] IDX_DEBUG_PORT_CONTROL = 16'h702A;
    localparam logic [15:0] IDX_SECOND_PLL_CONFIG = 16'h7030;
    localparam logic [15:0] IDX_SECOND_PLL_MULTIPLIER = 16'h7032;
    localparam logic [15:0] IDX_SECOND_PLL_LOCK_STATUS = 16'h7034;
    localparam logic [15:0] IDX_SECONDARY_CLOCK_COUNTER = 16'h7036;
    localparam logic [15:0] IDX_PWM_DMA_CONFIG = 16'h703A;
    localparam int NUM_REGS = 24;
    // ==================================================
    // field positions
    localparam int RATIO_LSB = 0; // 5-bit ratio in pll_ratio_control
    localparam int RATIO_W = 5;
    localparam int LOCK_BIT = 0; // pll_lock_flag in pll_status
    localparam int OUTPUT_DIVIDER_SELECT_LSB = 7; // output_divider_select in pll_status
    localparam int OSC1_OFF_BIT = 0; // clock_source_control bits
    localparam int OSC2_OFF_BIT = 1;
    localparam int SRC_SEL_BIT = 2; // 0 = internal_osc_one
    // ==================================================
    // reset values and limits
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_TRIM = 16'h0000;
    localparam logic [4:0] RATIO_MAX = 5'h12;
    localparam logic [1:0] OUTPUT_DIVIDER_SELECT_RST = 2'h0;
    // ==================================================
    // lock interval
    localparam int LOCK_TIME_US = 1000;
    localparam int CLK_MHZ = 10;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    // ==================================================
    // clock path mode
    typedef enum logic [1:0] {
        PCM_BYPASS,
        PCM_LOCKING,
        PCM_MULT
    } pcm_mode_e;
endpackage

// file: pcm_pll_clock_module.sv
`timescale 1ns/100ps
// Functional notes
// RULE_01 - writes only accepted while protected window open
// RULE_02 - system clock out equals cpu clock in
// RULE_03 - two oscillators on, osc one selected
// RULE_04 - software may power down each oscillator
// RULE_05 - trim registers set oscillator centre frequencies
// RULE_06 - five-bit ratio field sets multiplication
// RULE_07 - software disables watchdog before ratio write
// RULE_08 - lock takes 1 ms after ratio change
// RULE_09 - software keeps vco output at least 50 MHz
// RULE_10 - ratio zero bypass, n multiplies, divider select; here ratios above 18 clamp to 18
// RULE_11 - pll registers reset by pin or watchdog
// RULE_12 - debugger or missing-clock reset leaves pll registers
// RULE_13 - software sets divider zero before ratio write
// RULE_14 - ratio write forces bypass until lock
// RULE_15 - lock flag clears on write, sets after interval
module pcm_pll_clock_module #(
    parameter int LOCK_COUNT = pcm_pkg::LOCK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic external_reset_pin,
    input wire logic watchdog_reset,
    input wire logic protected_write_window,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [4:0] mult_factor,
    output logic [2:0] div_factor,
    output logic internal_osc_one_en,
    output logic internal_osc_two_en,
    output logic osc_select_two,
    output logic [15:0] osc_one_trim_val,
    output logic [15:0] osc_two_trim_val,
    output logic pll_locked
);
    import pcm_pkg::*;

    // ==================================================
    // address decode
    function automatic logic [4:0] reg_index(input logic [31:0] a);
        logic [15:0] w;
        w = a[17:2];
        if (a[1:0] != 2'h0 || a[31:18] != 14'h0) reg_index = 5'h1F;
        else if (w == IDX_BROWNOUT_CONFIG) reg_index = 5'h00;
        else if (w == IDX_CLOCK_OUTPUT_CONTROL) reg_index = 5'h01;
        else if (w == IDX_PLL_STATUS) reg_index = 5'h02;
        else if (w == IDX_CLOCK_SOURCE_CONTROL) reg_index = 5'h03;
        else if (w == IDX_PLL_LOCK_PERIOD) reg_index = 5'h04;
        else if (w == IDX_OSC_ONE_TRIM) reg_index = 5'h05;
        else if (w == IDX_OSC_TWO_TRIM) reg_index = 5'h06;
        else if (w == IDX_PERIPH_CLOCK_GATE_C) reg_index = 5'h07;
        else if (w == IDX_LOW_SPEED_PRESCALER) reg_index = 5'h08;
        else if (w == IDX_PERIPH_CLOCK_GATE_A) reg_index = 5'h09;
        else if (w == IDX_PERIPH_CLOCK_GATE_B) reg_index = 5'h0A;
        else if (w == IDX_LOW_POWER_CONTROL) reg_index = 5'h0B;
        else if (w == IDX_PERIPH_CLOCK_GATE_D) reg_index = 5'h0C;
        else if (w == IDX_PLL_RATIO_CONTROL) reg_index = 5'h0D;
        else if (w == IDX_SYSTEM_CONTROL_STATUS) reg_index = 5'h0E;
        else if (w == IDX_WATCHDOG_COUNTER) reg_index = 5'h0F;
        else if (w == IDX_WATCHDOG_KEY) reg_index = 5'h10;
        else if (w == IDX_WATCHDOG_CONTROL) reg_index = 5'h11;
        else if (w == IDX_DEBUG_PORT_CONTROL) reg_index = 5'h12;
        else if (w == IDX_SECOND_PLL_CONFIG) reg_index = 5'h13;
        else if (w == IDX_SECOND_PLL_MULTIPLIER) reg_index = 5'h14;
        else if (w == IDX_SECOND_PLL_LOCK_STATUS) reg_index = 5'h15;
        else if (w == IDX_SECONDARY_CLOCK_COUNTER) reg_index = 5'h16;
        else if (w == IDX_PWM_DMA_CONFIG) reg_index = 5'h17;
        else reg_index = 5'h1F;
    endfunction

    localparam logic [4:0] SLOT_STATUS = 5'h02;
    localparam logic [4:0] SLOT_SRC = 5'h03;
    localparam logic [4:0] SLOT_TRIM1 = 5'h05;
    localparam logic [4:0] SLOT_TRIM2 = 5'h06;
    localparam logic [4:0] SLOT_RATIO = 5'h0D;

    // ==================================================
    // window and pll-reset synchronisers
    // the window and both reset requests come from outside this clock, so each
    // passes two flops; only the second flop of each pair feeds any logic, which
    // costs two cycles of latency on the window and on a pll reset
    logic [1:0] win_sync_ff;
    logic [1:0] xrs_sync_ff;
    logic [1:0] wdr_sync_ff;
    logic [1:0] nxt_win_sync;
    logic [1:0] nxt_xrs_sync;
    logic [1:0] nxt_wdr_sync;
    logic pll_rst;

    // shift each raw input into its pair
    always_comb begin
        nxt_win_sync = {win_sync_ff[0], protected_write_window};
        nxt_xrs_sync = {xrs_sync_ff[0], external_reset_pin};
        nxt_wdr_sync = {wdr_sync_ff[0], watchdog_reset};
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            win_sync_ff <= 2'h0;
            xrs_sync_ff <= 2'h0;
            wdr_sync_ff <= 2'h0;
        end else begin
            win_sync_ff <= nxt_win_sync;
            xrs_sync_ff <= nxt_xrs_sync;
            wdr_sync_ff <= nxt_wdr_sync;
        end
    end

    // besides rst, only the pin or watchdog restore pll registers
    assign pll_rst = xrs_sync_ff[1] | wdr_sync_ff[1]; // RULE_11 RULE_12

    // ==================================================
    // apb access
    logic [4:0] slot;
    logic access;
    logic wr_ok;
    assign slot = reg_index(paddr);
    assign access = psel & penable;
    // protected window gates every write
    assign wr_ok = access & pwrite & win_sync_ff[1] & (slot != 5'h1F); // RULE_01

    // ==================================================
    // general register file
    // every mapped slot keeps its last accepted word; the watchdog, low-power and
    // gate registers are storage only here, their behaviour lives elsewhere
    logic [15:0] regs_ff [NUM_REGS];
    logic [15:0] nxt_regs [NUM_REGS];

    // plain storage, pll slots handled separately
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            nxt_regs[i] = regs_ff[i];
            if (wr_ok && slot == 5'(i)) nxt_regs[i] = pwdata[15:0]; // RULE_01
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= RST_ZERO; // RULE_03
        end else begin
            for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= nxt_regs[i];
        end
    end

    // ==================================================
    // pll ratio, divider select, lock
    // a ratio write restarts the lock count even mid-lock, so software that rewrites
    // the ratio before the flag returns only stretches the bypass interval; the
    // count is one step per clock, so the lock time scales with the clock period
    logic [4:0] ratio_ff, nxt_ratio;
    logic [1:0] output_divider_select_ff, nxt_output_divider_select;
    logic [31:0] lock_cnt_ff, nxt_lock_cnt;
    pcm_mode_e mode_ff, nxt_mode;
    logic ratio_wr;
    assign ratio_wr = wr_ok && slot == SLOT_RATIO;

    always_comb begin
        nxt_ratio = ratio_ff;
        nxt_output_divider_select = output_divider_select_ff;
        nxt_lock_cnt = lock_cnt_ff;
        nxt_mode = mode_ff;
        if (wr_ok && slot == SLOT_STATUS) nxt_output_divider_select = pwdata[OUTPUT_DIVIDER_SELECT_LSB +: 2];
        case (mode_ff)
            PCM_BYPASS, PCM_MULT: begin
            end
            PCM_LOCKING: begin
                if (lock_cnt_ff >= 32'(LOCK_COUNT - 1)) begin
                    nxt_mode = (ratio_ff == 5'h0) ? PCM_BYPASS : PCM_MULT; // RULE_14
                end else begin
                    nxt_lock_cnt = lock_cnt_ff + 32'h1; // RULE_08
                end
            end
            default: nxt_mode = PCM_BYPASS;
        endcase
        if (ratio_wr) begin
            nxt_ratio = pwdata[RATIO_LSB +: RATIO_W]; // RULE_06
            nxt_lock_cnt = 32'h0;
            nxt_mode = PCM_LOCKING; // RULE_14 RULE_15
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ratio_ff <= 5'h0;
            output_divider_select_ff <= OUTPUT_DIVIDER_SELECT_RST;
            lock_cnt_ff <= 32'h0;
            mode_ff <= PCM_BYPASS;
        end else if (pll_rst) begin
            ratio_ff <= 5'h0; // RULE_11
            output_divider_select_ff <= OUTPUT_DIVIDER_SELECT_RST;
            lock_cnt_ff <= 32'h0;
            mode_ff <= PCM_BYPASS;
        end else begin
            ratio_ff <= nxt_ratio;
            output_divider_select_ff <= nxt_output_divider_select;
            lock_cnt_ff <= nxt_lock_cnt;
            mode_ff <= nxt_mode;
        end
    end

    // ==================================================
    // frequency plan outputs
    logic [4:0] nxt_mult;
    logic [2:0] nxt_div;
    logic nxt_locked;
    logic [15:0] status_val;
    logic nxt_osc_one_en;
    logic nxt_osc_two_en;
    logic nxt_select_two;
    logic [15:0] nxt_trim_one;
    logic [15:0] nxt_trim_two;

    always_comb begin
        // multiplier 1 while bypassed or locking, ratios above max clamp
        if (mode_ff == PCM_MULT) begin // RULE_14
            nxt_mult = (ratio_ff > RATIO_MAX) ? RATIO_MAX : ratio_ff; // RULE_10
        end else begin
            nxt_mult = 5'h1;
        end
        case (output_divider_select_ff) // RULE_10
            2'h2: nxt_div = 3'h2;
            2'h3: nxt_div = 3'h1;
            default: nxt_div = 3'h4;
        endcase
        nxt_locked = (mode_ff != PCM_LOCKING); // RULE_15
        status_val = 16'h0;
        status_val[LOCK_BIT] = pll_locked;
        status_val[OUTPUT_DIVIDER_SELECT_LSB +: 2] = output_divider_select_ff;
        // oscillator controls follow clock_source_control and the trim slots
        nxt_osc_one_en = ~regs_ff[SLOT_SRC][OSC1_OFF_BIT]; // RULE_04
        nxt_osc_two_en = ~regs_ff[SLOT_SRC][OSC2_OFF_BIT]; // RULE_04
        nxt_select_two = regs_ff[SLOT_SRC][SRC_SEL_BIT]; // RULE_03
        nxt_trim_one = regs_ff[SLOT_TRIM1]; // RULE_05
        nxt_trim_two = regs_ff[SLOT_TRIM2]; // RULE_05
    end

    // cpu clock and system clock out share this one factor pair
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mult_factor <= 5'h1;
            div_factor <= 3'h4;
            pll_locked <= 1'b1;
            internal_osc_one_en <= 1'b1;
            internal_osc_two_en <= 1'b1;
            osc_select_two <= 1'b0;
            osc_one_trim_val <= RST_TRIM;
            osc_two_trim_val <= RST_TRIM;
        end else begin
            mult_factor <= nxt_mult; // RULE_02
            div_factor <= nxt_div; // RULE_02
            pll_locked <= nxt_locked;
            internal_osc_one_en <= nxt_osc_one_en;
            internal_osc_two_en <= nxt_osc_two_en;
            osc_select_two <= nxt_select_two;
            osc_one_trim_val <= nxt_trim_one;
            osc_two_trim_val <= nxt_trim_two;
        end
    end

    // ==================================================
    // apb read data, zero-wait answer, error on unmapped
    // the answer is prepared from the setup cycle, so pready is a registered
    // one-cycle pulse in the access phase and a master never sees a wait state
    logic [31:0] nxt_prdata;
    logic nxt_pready;
    logic nxt_pslverr;

    always_comb begin
        nxt_prdata = 32'h0;
        nxt_pready = psel & ~penable;
        nxt_pslverr = 1'b0;
        if (psel && !penable) begin
            if (slot == 5'h1F) nxt_pslverr = 1'b1;
            else if (slot == SLOT_STATUS) nxt_prdata = {16'h0, status_val};
            else if (slot == SLOT_RATIO) nxt_prdata = {27'h0, ratio_ff};
            else nxt_prdata = {16'h0, regs_ff[slot]};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= nxt_prdata;
            pready <= nxt_pready;
            pslverr <= nxt_pslverr;
        end
    end

    // ==================================================
    // checks
    // lock flag and bypass across a ratio change
    a_lock_clears: assert property (@(posedge mclk) disable iff (rst || pll_rst) // RULE_15
        ratio_wr |=> ##1 !pll_locked)
        else $error("lock flag not cleared");

    a_bypass_locking: assert property (@(posedge mclk) disable iff (rst) // RULE_14
        mode_ff == PCM_LOCKING |=> mult_factor == 5'h1)
        else $error("not bypassed");

    a_locked_waits: assert property (@(posedge mclk) disable iff (rst || pll_rst) // RULE_08
        ratio_wr |=> (mode_ff == PCM_LOCKING) [*3])
        else $error("lock too early");

    a_lock_ends: assert property (@(posedge mclk) disable iff (rst || pll_rst) // RULE_08
        mode_ff == PCM_LOCKING && lock_cnt_ff == 32'(LOCK_COUNT - 1) && !ratio_wr
        |=> ##1 pll_locked)
        else $error("lock flag late");

    // closed window leaves pll and plain registers alone
    a_protect_write: assert property (@(posedge mclk) disable iff (rst || pll_rst) // RULE_01
        access && pwrite && !win_sync_ff[1] |=> $stable(ratio_ff))
        else $error("unprotected write took");

    a_protect_trim: assert property (@(posedge mclk) disable iff (rst) // RULE_01
        access && pwrite && !win_sync_ff[1] |=> $stable(regs_ff[SLOT_TRIM1]))
        else $error("unprotected trim write took");

    // divider select and multiplier reach the factor outputs
    a_div_select: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        output_divider_select_ff == 2'h3 |=> div_factor == 3'h1)
        else $error("divider wrong");

    a_div_half: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        output_divider_select_ff == 2'h2 |=> div_factor == 3'h2)
        else $error("half divider wrong");

    a_div_quarter: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        output_divider_select_ff < 2'h2 |=> div_factor == 3'h4)
        else $error("quarter divider wrong");

    a_bypass_zero: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        mode_ff == PCM_BYPASS |=> mult_factor == 5'h1)
        else $error("bypass multiplier wrong");

    a_mult_locked: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        mode_ff == PCM_MULT && ratio_ff <= RATIO_MAX |=> mult_factor == $past(ratio_ff))
        else $error("multiplier wrong");

    a_mult_clamp: assert property (@(posedge mclk) disable iff (rst) // RULE_10
        mode_ff == PCM_MULT && ratio_ff > RATIO_MAX |=> mult_factor == RATIO_MAX)
        else $error("multiplier not clamped");

    // pll reset and ratio storage
    a_pll_reset: assert property (@(posedge mclk) disable iff (rst) // RULE_11
        pll_rst |=> ratio_ff == 5'h0 && output_divider_select_ff == 2'h0)
        else $error("pll reset missed");

    a_ratio_store: assert property (@(posedge mclk) disable iff (rst || pll_rst) // RULE_06
        ratio_wr |=> ratio_ff == $past(pwdata[4:0]))
        else $error("ratio not stored");

    // oscillator controls and trims
    a_osc_one_off: assert property (@(posedge mclk) disable iff (rst) // RULE_04
        regs_ff[SLOT_SRC][OSC1_OFF_BIT] |=> !internal_osc_one_en)
        else $error("osc one not powered down");

    a_osc_two_off: assert property (@(posedge mclk) disable iff (rst) // RULE_04
        regs_ff[SLOT_SRC][OSC2_OFF_BIT] |=> !internal_osc_two_en)
        else $error("osc two not powered down");

    a_trim_out: assert property (@(posedge mclk) disable iff (rst) // RULE_05
        wr_ok && slot == SLOT_TRIM1 |=> ##1 osc_one_trim_val == $past(pwdata[15:0], 2))
        else $error("trim lost");

    // bus answer
    a_ready_pulse: assert property (@(posedge mclk) disable iff (rst)
        psel && !penable |=> pready)
        else $error("no ready in access phase");

    a_slverr_unmapped: assert property (@(posedge mclk) disable iff (rst)
        psel && !penable && slot == 5'h1F |=> pslverr)
        else $error("no error on unmapped access");
endmodule // pcm_pll_clock_module

// file: pcm_pll_clock_module_bench.sv
`timescale 1ns/100ps
module pcm_pll_clock_module_bench;
    import pcm_pkg::*;
    localparam int LC = 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic external_reset_pin = 1'b0;
    logic watchdog_reset = 1'b0;
    logic protected_write_window = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] mult_factor;
    logic [2:0] div_factor;
    logic osc_one_en;
    logic osc_two_en;
    logic osc_sel_two;
    logic [15:0] trim_one;
    logic [15:0] trim_two;
    logic pll_locked;
    logic [31:0] rd;
    logic err;
    logic [15:0] t1;
    logic [15:0] t2;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    pcm_pll_clock_module #(.LOCK_COUNT(LC)) u_pcm_pll_clock_module (
        .mclk(mclk), .rst(rst), .external_reset_pin(external_reset_pin),
        .watchdog_reset(watchdog_reset), .protected_write_window(protected_write_window),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mult_factor(mult_factor),
        .div_factor(div_factor), .internal_osc_one_en(osc_one_en),
        .internal_osc_two_en(osc_two_en), .osc_select_two(osc_sel_two),
        .osc_one_trim_val(trim_one), .osc_two_trim_val(trim_two), .pll_locked(pll_locked)
    );

    // ==================================================
    // clock and run limit
    always #50 mclk = ~mclk;

    // cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report;
        end
    end

    // ==================================================
    // helpers
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [4:0] exp_mult(input logic [4:0] r);
        if (r == 5'h00) return 5'h01;
        if (r > RATIO_MAX) return RATIO_MAX;
        return r;
    endfunction

    function automatic logic [2:0] exp_div(input logic [1:0] d);
        return (d == 2'h3) ? 3'h1 : (d == 2'h2) ? 3'h2 : 3'h4;
    endfunction

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= {16'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_window(input logic v);
        protected_write_window <= v;
        repeat (3) @(posedge mclk);
    endtask

    // ratio write: bypass while locking, then the multiplied rate
    task automatic ratio_case(input logic [15:0] v);
        int lows;
        int n;
        lows = 0;
        n = 0;
        // watchdog held off across the ratio change until lock is read back
        watchdog_reset <= 1'b0;
        apb(1'b1, IDX_PLL_RATIO_CONTROL, v);
        do begin
            @(negedge mclk);
            n++;
        end while (pll_locked !== 1'b0 && n < 4);
        while (pll_locked === 1'b0 && lows < 40) begin
            check("bypass_mult", mult_factor, 5'h01);
            lows++;
            @(negedge mclk);
        end
        check("lock_cycles", lows, LC);
        repeat (2) @(negedge mclk);
        check("mult", mult_factor, exp_mult(v[4:0]));
        apb(1'b0, IDX_PLL_RATIO_CONTROL, 16'h0);
        check("ratio_rd", rd, {27'h0, v[4:0]});
        apb(1'b0, IDX_PLL_STATUS, 16'h0);
        check("lock_rd", rd[LOCK_BIT], 1'b1);
    endtask

    // ==================================================
    // main sequence
    initial begin
        void'($urandom(32'hE916181E));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check("rst_mult", mult_factor, 5'h01);
        check("rst_div", div_factor, 3'h4);
        check("rst_osc", {osc_one_en, osc_two_en, osc_sel_two}, 3'h6);
        check("rst_lock", pll_locked, 1'b1);
        // closed window: writes are dropped
        apb(1'b1, IDX_OSC_ONE_TRIM, 16'hA5A5);
        apb(1'b1, IDX_PLL_RATIO_CONTROL, 16'h0005);
        repeat (12) @(posedge mclk);
        check("closed_trim", trim_one, RST_TRIM);
        check("closed_lock", pll_locked, 1'b1);
        apb(1'b0, IDX_PLL_RATIO_CONTROL, 16'h0);
        check("closed_ratio", rd, 32'h0);
        check("mapped_err", err, 1'b0);
        set_window(1'b1);
        // divider select held at zero for every ratio write
        ratio_case(16'h0000);
        ratio_case(16'h0012);
        ratio_case(16'hFFFF);
        // random ratios keep a 10 MHz oscillator at or above 50 MHz on the vco
        repeat (4) ratio_case(16'($urandom_range(5, 18)));
        for (int d = 3; d >= 0; d--) begin
            apb(1'b1, IDX_PLL_STATUS, 16'(d) << OUTPUT_DIVIDER_SELECT_LSB);
            repeat (3) @(posedge mclk);
            check("div", div_factor, exp_div(2'(d)));
        end
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, IDX_CLOCK_SOURCE_CONTROL, 16'(s));
            repeat (3) @(posedge mclk);
            check("osc", {osc_one_en, osc_two_en, osc_sel_two}, {~s[0], ~s[1], s[2]});
        end
        t1 = 16'($urandom);
        t2 = 16'($urandom);
        apb(1'b1, IDX_OSC_ONE_TRIM, t1);
        apb(1'b1, IDX_OSC_TWO_TRIM, t2);
        repeat (3) @(posedge mclk);
        check("trim", {trim_one, trim_two}, {t1, t2});
        // pin reset and watchdog reset restore the pll state only
        for (int i = 0; i < 2; i++) begin
            ratio_case(16'h0007);
            apb(1'b1, IDX_PLL_STATUS, 16'h2 << OUTPUT_DIVIDER_SELECT_LSB);
            if (i == 0) external_reset_pin <= 1'b1;
            else watchdog_reset <= 1'b1;
            repeat (4) @(posedge mclk);
            external_reset_pin <= 1'b0;
            watchdog_reset <= 1'b0;
            repeat (4) @(posedge mclk);
            check("pin_rst_mult", mult_factor, 5'h01);
            check("pin_rst_div", div_factor, 3'h4);
            check("pin_rst_trim", {trim_one, trim_two}, {t1, t2});
            apb(1'b0, IDX_PLL_RATIO_CONTROL, 16'h0);
            check("pin_rst_ratio", rd, 32'h0);
        end
        apb(1'b0, 16'h7015, 16'h0);
        check("unmapped_err", err, 1'b1);
        final_report;
    end
endmodule // pcm_pll_clock_module_bench
